/* File: atdf_pkg.sv */
// constants shared by the async transmit descriptor fetch block
// assumes a 32-bit host memory word port and an apb register bus
package atdf_pkg;
    // apb register byte offsets
    localparam logic [7:0] ATDF_OFS_CTRL = 8'h00;
    localparam logic [7:0] ATDF_OFS_CMDPTR = 8'h04;
    localparam logic [7:0] ATDF_OFS_STATUS = 8'h08;
    localparam logic [7:0] ATDF_OFS_STAMP = 8'h0c;
    // control bits
    localparam int ATDF_CTRL_RUN_BIT = 0;
    localparam int ATDF_CTRL_CLRERR_BIT = 1;
    localparam logic [31:0] ATDF_CMDPTR_RST = 32'h0000_0000;
    // descriptor word 0 fields
    localparam int ATDF_CMD_MSB = 31;
    localparam int ATDF_CMD_LSB = 28;
    localparam int ATDF_S_BIT = 27;
    localparam int ATDF_KEY_MSB = 26;
    localparam int ATDF_KEY_LSB = 24;
    localparam int ATDF_INT_MSB = 21;
    localparam int ATDF_INT_LSB = 20;
    localparam logic [3:0] ATDF_CMD_LAST_IMM = 4'h1;
    localparam logic [2:0] ATDF_KEY_IMM = 3'h2;
    // word offsets from the start of a descriptor
    localparam logic [4:0] ATDF_W_BRANCH = 5'h02;
    localparam logic [4:0] ATDF_W_STATUS = 5'h03;
    localparam logic [4:0] ATDF_W_HDR = 5'h04;
    localparam logic [31:0] ATDF_STATUS_BYTE = 32'h0000_000c;
    // block count limits
    localparam logic [3:0] ATDF_Z_END = 4'h0;
    localparam logic [3:0] ATDF_Z_MIN = 4'h2;
    localparam logic [3:0] ATDF_Z_MAX = 4'h8;
    // interrupt select codes
    localparam logic [1:0] ATDF_INT_ALWAYS = 2'b11;
    localparam logic [1:0] ATDF_INT_ERR = 2'b01;
    localparam logic [1:0] ATDF_INT_NEVER = 2'b00;
    // acknowledge codes, values arbitrary
    localparam logic [3:0] ATDF_ACK_COMPLETE = 4'h1;
    localparam logic [3:0] ATDF_ACK_PENDING = 4'h2;
    typedef enum logic [5:0] {
        ATDF_ST_IDLE = 6'b000001,
        ATDF_ST_FETCH = 6'b000010,
        ATDF_ST_PUSH = 6'b000100,
        ATDF_ST_ACK = 6'b001000,
        ATDF_ST_STAT = 6'b010000,
        ATDF_ST_HALT = 6'b100000
    } atdf_state_t;
endpackage

/* File: atdf_top.sv */
// async transmit descriptor fetch: fetches descriptor blocks, pushes
// header quadlets, writes status and time stamp back to memory.
// assumes memory, fifo, ack and timer inputs run on pclk.
// Operation
// - time field: 3 seconds bits, 13 cycle bits
// - cycle number copied whole from timer
// - stamp taken when acknowledge arrives
// - stamp taken at acknowledge timeout
// - status and stamp in one write
// - status field gets low context control bits
// - immediate descriptor always 32 bytes
// - push up to four header quadlets
// - block count zero ends the program
// - block counts 1 and 9-15 reserved
// - counts 2-8 fetch contiguous 16-byte units
// - one block fully describes one packet
// - branch taken from last descriptor only
// - program ends zero, may be appended
// - immediate carries command 1, key 2
// - interrupt select decides completion event
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module atdf_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host memory word port
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // transmit fifo push
    output logic fifo_valid,
    output logic [31:0] fifo_data,
    input wire logic fifo_ready,
    // link acknowledge
    input wire logic ack_valid,
    input wire logic [3:0] ack_code,
    input wire logic ack_timeout,
    // cycle timer and context control
    input wire logic [6:0] timer_second_bits,
    input wire logic [12:0] timer_cycle_number,
    input wire logic [15:0] context_control_word,
    // completion and state
    output logic completion_event,
    output logic desc_error
);
    import atdf_pkg::*;

    atdf_state_t state_q;
    logic [31:0] prdata_q, cmdptr_q, ptr_q, mem_addr_q, mem_wdata_q, fifo_data_q;
    logic pready_q, pslverr_q, go_q, clr_q, mem_req_q, mem_we_q, fifo_valid_q;
    logic evt_q, err_q;
    logic [3:0] z_q;
    logic [5:0] idx_q;
    logic [2:0] push_q;
    logic [15:0] stamp_q;
    logic [31:0] desc_q [0:31];
    logic [4:0] last_base;
    logic [31:0] last_w0, last_br, first_w0;
    logic [2:0] hdr_q;
    logic [5:0] nwords;
    logic wr_en, ack_evt, ack_good, z_bad, first_bad;

    assign wr_en = psel & penable & pready_q & pwrite;
    assign ack_evt = ack_valid | ack_timeout;
    assign ack_good = ack_valid & ((ack_code == ATDF_ACK_COMPLETE) |
        (ack_code == ATDF_ACK_PENDING));
    assign nwords = {z_q, 2'b00};
    assign last_base = (z_q == ATDF_Z_MIN) ? 5'h00 : {z_q[2:0] - 3'h1, 2'b00};
    assign last_w0 = desc_q[last_base];
    assign last_br = desc_q[last_base + ATDF_W_BRANCH];
    assign first_w0 = desc_q[0];
    // header quadlet count from byte count
    assign hdr_q = first_w0[4:2];
    // block must open with immediate command
    assign first_bad = (first_w0[ATDF_CMD_MSB:ATDF_CMD_LSB] != ATDF_CMD_LAST_IMM) |
        (first_w0[ATDF_KEY_MSB:ATDF_KEY_LSB] != ATDF_KEY_IMM);
    assign z_bad = (z_q == 4'h1) | (z_q > ATDF_Z_MAX);

    // apb slave, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            go_q <= 1'b0;
            clr_q <= 1'b0;
            cmdptr_q <= ATDF_CMDPTR_RST;
        end else begin
            pready_q <= psel & ~penable;
            go_q <= wr_en & (paddr == ATDF_OFS_CTRL) & pwdata[ATDF_CTRL_RUN_BIT];
            clr_q <= wr_en & (paddr == ATDF_OFS_CTRL) & pwdata[ATDF_CTRL_CLRERR_BIT];
            if (wr_en && paddr == ATDF_OFS_CMDPTR) begin
                cmdptr_q <= pwdata;
            end
            if (psel && !penable) begin
                pslverr_q <= 1'b0;
                case (paddr)
                    ATDF_OFS_CTRL: prdata_q <= 32'h0000_0000;
                    ATDF_OFS_CMDPTR: prdata_q <= cmdptr_q;
                    ATDF_OFS_STATUS: prdata_q <= {24'h00_0000, 2'b00, state_q};
                    ATDF_OFS_STAMP: prdata_q <= {16'h0000, stamp_q};
                    default: begin
                        prdata_q <= 32'h0000_0000;
                        pslverr_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // descriptor engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ATDF_ST_IDLE;
            ptr_q <= 32'h0000_0000;
            z_q <= ATDF_Z_END;
            idx_q <= 6'h00;
            push_q <= 3'h0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
            mem_wdata_q <= 32'h0000_0000;
            fifo_valid_q <= 1'b0;
            fifo_data_q <= 32'h0000_0000;
            stamp_q <= 16'h0000;
            evt_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            evt_q <= 1'b0;
            case (state_q)
                ATDF_ST_IDLE: begin
                    if (go_q) begin
                        ptr_q <= {cmdptr_q[31:4], 4'h0};
                        z_q <= cmdptr_q[3:0];
                        idx_q <= 6'h00;
                        if (cmdptr_q[3:0] == ATDF_Z_END) begin
                            state_q <= ATDF_ST_IDLE;
                        end else if (cmdptr_q[3:0] == 4'h1 || cmdptr_q[3:0] > ATDF_Z_MAX) begin
                            state_q <= ATDF_ST_HALT;
                            err_q <= 1'b1;
                        end else begin
                            state_q <= ATDF_ST_FETCH;
                            mem_req_q <= 1'b1;
                            mem_we_q <= 1'b0;
                            mem_addr_q <= {cmdptr_q[31:4], 4'h0};
                        end
                    end
                end
                ATDF_ST_FETCH: begin
                    // whole block prefetched, immediate as two units
                    if (mem_ack) begin
                        idx_q <= idx_q + 6'h01;
                        mem_addr_q <= mem_addr_q + 32'h0000_0004;
                        if (idx_q == nwords - 6'h01) begin
                            mem_req_q <= 1'b0;
                            push_q <= 3'h0;
                            state_q <= ATDF_ST_PUSH;
                        end
                    end
                end
                ATDF_ST_PUSH: begin
                    if (first_bad) begin
                        state_q <= ATDF_ST_HALT;
                        err_q <= 1'b1;
                    end else if (!fifo_valid_q || fifo_ready) begin
                        if (push_q < hdr_q && push_q < 3'h4) begin
                            fifo_valid_q <= 1'b1;
                            fifo_data_q <= desc_q[ATDF_W_HDR + {2'b00, push_q}];
                            push_q <= push_q + 3'h1;
                        end else begin
                            fifo_valid_q <= 1'b0;
                            state_q <= ATDF_ST_ACK;
                        end
                    end
                end
                ATDF_ST_ACK: begin
                    if (ack_evt) begin
                        stamp_q <= {timer_second_bits[2:0], timer_cycle_number};
                        evt_q <= (last_w0[ATDF_INT_MSB:ATDF_INT_LSB] == ATDF_INT_ALWAYS) |
                            ((last_w0[ATDF_INT_MSB:ATDF_INT_LSB] == ATDF_INT_ERR) & ~ack_good);
                        if (last_w0[ATDF_S_BIT]) begin
                            // one write of status and stamp
                            state_q <= ATDF_ST_STAT;
                            mem_req_q <= 1'b1;
                            mem_we_q <= 1'b1;
                            mem_addr_q <= ptr_q + {25'h000_0000, last_base, 2'b00} +
                                ATDF_STATUS_BYTE;
                            mem_wdata_q <= {context_control_word,
                                timer_second_bits[2:0], timer_cycle_number};
                        end else begin
                            ptr_q <= {last_br[31:4], 4'h0};
                            z_q <= last_br[3:0];
                            state_q <= ATDF_ST_IDLE;
                        end
                    end
                end
                ATDF_ST_STAT: begin
                    if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        mem_we_q <= 1'b0;
                        ptr_q <= {last_br[31:4], 4'h0};
                        z_q <= last_br[3:0];
                        state_q <= ATDF_ST_IDLE;
                    end
                end
                ATDF_ST_HALT: begin
                    if (clr_q) begin
                        err_q <= 1'b0;
                        // stopped context must not chain again
                        z_q <= ATDF_Z_END;
                        state_q <= ATDF_ST_IDLE;
                    end
                end
                default: state_q <= ATDF_ST_IDLE;
            endcase
            // chain to next block without software
            if (state_q == ATDF_ST_IDLE && !go_q && z_q != ATDF_Z_END) begin
                idx_q <= 6'h00;
                if (z_bad) begin
                    state_q <= ATDF_ST_HALT;
                    err_q <= 1'b1;
                end else begin
                    state_q <= ATDF_ST_FETCH;
                    mem_req_q <= 1'b1;
                    mem_we_q <= 1'b0;
                    mem_addr_q <= ptr_q;
                end
            end
        end
    end

    // descriptor storage
    always_ff @(posedge pclk) begin
        if (state_q == ATDF_ST_FETCH && mem_ack) begin
            desc_q[idx_q[4:0]] <= mem_rdata;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign mem_req = mem_req_q;
    assign mem_we = mem_we_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    assign fifo_valid = fifo_valid_q;
    assign fifo_data = fifo_data_q;
    assign completion_event = evt_q;
    assign desc_error = err_q;

    property p_stamp_layout;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ATDF_ST_ACK && ack_valid) |=>
            stamp_q[15:13] == $past(timer_second_bits[2:0]);
    endproperty
    a_stamp_layout: assert property (p_stamp_layout) else $error("stamp seconds wrong");
    property p_stamp_cycle;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ATDF_ST_ACK && ack_timeout) |=> stamp_q[12:0] == $past(timer_cycle_number);
    endproperty
    a_stamp_cycle: assert property (p_stamp_cycle) else $error("stamp cycle wrong");
    property p_one_write;
        @(posedge pclk) disable iff (!presetn)
        (mem_req_q && mem_we_q) |-> mem_wdata_q[15:0] == stamp_q && state_q == ATDF_ST_STAT;
    endproperty
    a_one_write: assert property (p_one_write) else $error("status write lacks stamp");
    property p_ctx_copy;
        @(posedge pclk) disable iff (!presetn)
        $rose(mem_we_q) |-> mem_wdata_q[31:16] == $past(context_control_word);
    endproperty
    a_ctx_copy: assert property (p_ctx_copy) else $error("status not context word");
    property p_fetch_len;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ATDF_ST_FETCH && $past(state_q) != ATDF_ST_FETCH) |->
            (mem_req_q && !mem_we_q) [*2];
    endproperty
    a_fetch_len: assert property (p_fetch_len) else $error("fetch shorter than two words");
    property p_push_max;
        @(posedge pclk) disable iff (!presetn)
        fifo_valid_q |-> push_q <= 3'h4 && push_q >= 3'h1;
    endproperty
    a_push_max: assert property (p_push_max) else $error("too many header quadlets");
    property p_end;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ATDF_ST_IDLE && go_q && cmdptr_q[3:0] == ATDF_Z_END) |=>
            state_q == ATDF_ST_IDLE ##1 !mem_req_q;
    endproperty
    a_end: assert property (p_end) else $error("zero count started fetch");
    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ATDF_ST_IDLE && go_q && cmdptr_q[3:0] == 4'h1) |=>
            state_q == ATDF_ST_HALT && err_q;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved count not halted");
    property p_branch;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ATDF_ST_STAT && mem_ack) |=> z_q == $past(last_br[3:0]);
    endproperty
    a_branch: assert property (p_branch) else $error("branch not from last descriptor");
    property p_int_never;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ATDF_ST_ACK && ack_evt &&
            last_w0[ATDF_INT_MSB:ATDF_INT_LSB] == ATDF_INT_NEVER) |=> !evt_q;
    endproperty
    a_int_never: assert property (p_int_never) else $error("event with select never");
endmodule

/* File: atdf_mem_model.sv */
// host memory model holding descriptor programs for the fetch block
// assumes one word port on pclk; ack pulse completes the current word
`timescale 1ns/100ps
module atdf_mem_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // answer speed
    input wire logic slow,
    // word port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic [7:0] wr_cnt
);
    logic [31:0] mem [0:63];
    logic [1:0] wait_q;
    logic [31:0] last_q;
    // idle bus shows inverse of last word
    assign mem_rdata = mem_ack ? mem[mem_addr[7:2]] : ~last_q;
    // one word write holds status and stamp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_q <= 2'd0;
            wr_cnt <= 8'h00;
            last_q <= 32'h0000_0000;
        end else begin
            mem_ack <= 1'b0;
            if (mem_req && mem_ack) begin
                last_q <= mem_rdata;
                if (mem_we) begin
                    mem[mem_addr[7:2]] <= mem_wdata;
                    wr_cnt <= wr_cnt + 8'h01;
                end
            end else if (mem_req) begin
                if (wait_q == (slow ? 2'd2 : 2'd0)) begin
                    mem_ack <= 1'b1;
                    wait_q <= 2'd0;
                end else begin
                    wait_q <= wait_q + 2'd1;
                end
            end
        end
    end
endmodule

/* File: tb.sv */
// self-checking bench for the async transmit descriptor fetch block
// assumes the memory model above and the apb timing of the hand-over
`timescale 1ns/100ps
module tb;
    import atdf_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, mem_addr, mem_wdata, mem_rdata, fifo_data;
    logic pready, pslverr, mem_req, mem_we, mem_ack, fifo_valid, completion_event, desc_error;
    logic fifo_ready = 1'b0, ack_valid = 1'b0, ack_timeout = 1'b0, slow = 1'b0;
    logic [3:0] ack_code = 4'h0;
    logic [6:0] timer_second_bits = 7'h00;
    logic [12:0] timer_cycle_number = 13'h0000;
    logic [15:0] context_control_word = 16'h0000;
    logic [7:0] wr_cnt, stall_q = 8'h00;
    logic [31:0] push_q [$];
    logic [31:0] rd;
    logic err;
    int fails = 0, check_count = 0, ev_cnt = 0;
    initial forever #10 pclk = ~pclk;
    atdf_top atdf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_ready(fifo_ready),
        .ack_valid(ack_valid), .ack_code(ack_code), .ack_timeout(ack_timeout),
        .timer_second_bits(timer_second_bits), .timer_cycle_number(timer_cycle_number),
        .context_control_word(context_control_word), .completion_event(completion_event),
        .desc_error(desc_error));
    atdf_mem_model atdf_mem_model_i (.pclk(pclk), .presetn(presetn), .slow(slow),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .wr_cnt(wr_cnt));
    // fifo stalls one cycle in four; pushes and events logged
    always @(posedge pclk) begin
        stall_q <= stall_q + 8'h01;
        fifo_ready <= (stall_q[1:0] != 2'd3);
        if (fifo_valid === 1'b1 && fifo_ready === 1'b1) push_q.push_back(fifo_data);
        if (completion_event === 1'b1) ev_cnt++;
    end
    task results;
        if (fails == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin fails++; results(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_push(input int cnt);
        int n;
        for (n = 0; n < 800 && push_q.size() < cnt; n++) @(posedge pclk);
        if (n == 800) begin fails++; results(); end
        repeat (4) @(posedge pclk);
    endtask
    task pulse_ack(input logic tmo, input logic [3:0] code);
        ack_valid <= ~tmo;
        ack_timeout <= tmo;
        ack_code <= code;
        @(posedge pclk);
        ack_valid <= 1'b0;
        ack_timeout <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task regs_scn;
        apb(1'b0, ATDF_OFS_CMDPTR, 32'h0); chk("cmdptr", ATDF_CMDPTR_RST, rd);
        apb(1'b1, ATDF_OFS_STATUS, 32'hffff_ffff);
        apb(1'b0, ATDF_OFS_STATUS, 32'h0); chk("idle", 32'h0000_0001, rd);
        apb(1'b1, 8'h10, 32'h1); chk("slverr", 32'h1, {31'h0, err});
        apb(1'b0, 8'h10, 32'h0); chk("unmapped", 32'h0, rd);
    endtask
    // three chained blocks: counts 2, 3, 2 then end
    task chain_scn;
        timer_second_bits <= 7'h5d; timer_cycle_number <= 13'd7999;
        context_control_word <= 16'ha5c3;
        apb(1'b1, ATDF_OFS_CMDPTR, 32'h0000_0002);
        apb(1'b1, ATDF_OFS_CTRL, 32'h1);
        wait_push(4);
        chk("pushes a", 32'd4, push_q.size());
        pulse_ack(1'b0, ATDF_ACK_COMPLETE);
        chk("status a", 32'ha5c3_bf3f, atdf_mem_model_i.mem[3]);
        chk("event a", 32'd1, ev_cnt);
        timer_second_bits <= 7'h02; timer_cycle_number <= 13'd0;
        context_control_word <= 16'h0011;
        wait_push(6);
        chk("pushes b", 32'd6, push_q.size());
        pulse_ack(1'b1, 4'h0);
        chk("status b", 32'h0011_4000, atdf_mem_model_i.mem[27]);
        chk("event b", 32'd2, ev_cnt);
        wait_push(9);
        pulse_ack(1'b0, ATDF_ACK_COMPLETE);
        repeat (10) @(posedge pclk);
        chk("event c", 32'd2, ev_cnt);
        chk("writes", 32'd2, {24'h0, wr_cnt});
        chk("untouched c", 32'h0, atdf_mem_model_i.mem[35]);
        foreach (push_q[i]) chk("push", 32'hd000_0000 + i, push_q[i]);
        apb(1'b0, ATDF_OFS_STATUS, 32'h0); chk("ended", 32'h1, rd);
        apb(1'b1, ATDF_OFS_CMDPTR, 32'h0000_0000);
        apb(1'b1, ATDF_OFS_CTRL, 32'h1);
        apb(1'b0, ATDF_OFS_STATUS, 32'h0); chk("zero start", 32'h1, rd);
        chk("no fetch", 32'h0, {31'h0, mem_req});
    endtask
    // reserved counts and a bad key halt with error
    task automatic reserved_scn;
        logic [3:0] zs [4] = '{4'h1, 4'h9, 4'hf, 4'h2};
        int n;
        slow <= 1'b1;
        foreach (zs[i]) begin
            apb(1'b1, ATDF_OFS_CMDPTR, {28'h0000_00c, zs[i]});
            apb(1'b1, ATDF_OFS_CTRL, 32'h1);
            for (n = 0; n < 200 && desc_error !== 1'b1; n++) @(posedge pclk);
            chk("error", 32'h1, {31'h0, desc_error});
            apb(1'b0, ATDF_OFS_STATUS, 32'h0); chk("halt", 32'h20, rd);
            apb(1'b1, ATDF_OFS_CTRL, 32'h2);
            repeat (3) @(posedge pclk);
            chk("cleared", 32'h0, {31'h0, desc_error});
            apb(1'b0, ATDF_OFS_STATUS, 32'h0); chk("stopped", 32'h1, rd);
        end
        chk("no push", 32'd9, push_q.size());
    endtask
    initial begin
        for (int i = 0; i < 64; i++) atdf_mem_model_i.mem[i] = 32'h0;
        atdf_mem_model_i.mem[0] = 32'h1a3c_0010;
        atdf_mem_model_i.mem[2] = 32'h0000_0043;
        for (int i = 0; i < 4; i++) atdf_mem_model_i.mem[4 + i] = 32'hd000_0000 + i;
        atdf_mem_model_i.mem[16] = 32'h120c_0008;
        atdf_mem_model_i.mem[18] = 32'h0000_00c2;
        atdf_mem_model_i.mem[20] = 32'hd000_0004;
        atdf_mem_model_i.mem[21] = 32'hd000_0005;
        atdf_mem_model_i.mem[24] = 32'h181c_0000;
        atdf_mem_model_i.mem[26] = 32'h0000_0082;
        atdf_mem_model_i.mem[32] = 32'h120c_000c;
        for (int i = 0; i < 3; i++) atdf_mem_model_i.mem[36 + i] = 32'hd000_0006 + i;
        atdf_mem_model_i.mem[48] = 32'h130c_0010;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        regs_scn();
        chain_scn();
        reserved_scn();
        results();
    end
endmodule
